// ### verif/adfcr_host.sv
`timescale 1ns/1ps
`default_nettype none
module adfcr_host
  import adfcr_pkg::*;
(
  input wire logic ref_clk, // Bench clock
  input wire logic [7:0] rdata, // Device read data
  output var adfcr_bus_t bus // Control port strobes
);
  initial bus = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    bus = '{1'b1, 1'b0, a, d};
    @(negedge ref_clk);
    bus = '{1'b0, 1'b0, ~a, ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    bus = '{1'b0, 1'b1, a, 8'h00};
    @(negedge ref_clk);
    bus = '{1'b0, 1'b0, ~a, 8'hFF};
    @(negedge ref_clk);
    d = rdata;
  endtask : rd
endmodule : adfcr_host
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top import adfcr_pkg::*;;
  logic ref_clk = 0, rstn = 0, tk = 0, gp = 0, rec = 0;
  logic [2:0] lut = '0, att;
  logic [7:0] vb = '0, av = '0, rdata, v;
  logic shut;
  adfcr_regs_t act;
  adfcr_bus_t bus;
  int num_errors = 0, check_count = 0, cyc = 0;
  logic [7:0] A [7] = '{8'h20, 8'h23, 8'h24, 8'h2B, 8'h2C, 8'h2D, 8'h2E};
  logic [7:0] M [7] = '{8'hF4, 8'hF0, 8'hFF, 8'hFC, 8'hF0, 8'hFF, 8'hFF};
  always #25 ref_clk = ~ref_clk;
  adfcr_host host (.ref_clk(ref_clk), .rdata(rdata), .bus(bus));
  adfcr_regs dut (.ref_clk(ref_clk), .rstn(rstn), .bus(bus), .sample_tick(tk),
    .gpio_val(gp), .sar_lut_atten(lut), .sar_recovered(rec), .sar_vbat(vb),
    .sar_avdd(av), .rdata(rdata), .cfg_active(act), .plim_atten(att),
    .undervoltage_shutdown(shut));
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e)
    begin
      num_errors++;
      $display("[FAIL] %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  // Ticks spaced so each lands on its own edge
  task automatic pk(input int n);
    repeat (n)
    begin
      @(negedge ref_clk) tk = 1;
      @(negedge ref_clk) tk = 0;
    end
    repeat (2) @(negedge ref_clk);
  endtask : pk
  task automatic t_regs;
    for (int i = 0; i < 7; i++)
    begin
      host.rd(A[i], v);
      chk("reset", v, i == 6 ? 8'hBF : 8'h00);
      host.wr(A[i], 8'hFF);
      host.rd(A[i], v);
      chk("mask", v, M[i]);
      host.wr(A[i], 8'h00);
    end
    host.wr(8'h21, 8'hFF);
    host.rd(8'h21, v);
    chk("unmapped", v, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      host.wr(8'h20, {k[1:0], k[1:0], 4'h4});
      host.rd(8'h20, v);
      chk("clk", v, {k[1:0], k[1:0], 4'h4});
      host.wr(8'h23, {k[1:0], ~k[1:0], 4'h0});
      host.rd(8'h23, v);
      chk("lim", v, {k[1:0], ~k[1:0], 4'h0});
    end
  endtask : t_regs
  task automatic t_apply;
    host.wr(8'h2C, 8'hA0);
    chk("early", act.mixer, 8'h00);
    pk(1);
    chk("mixer", act.mixer, 8'hA0);
    host.wr(8'h24, 8'h96);
    pk(1);
    chk("gc", act.gc_en, 8'h96);
  endtask : t_apply
  task automatic t_uv;
    host.wr(8'h2E, 8'h80);
    host.wr(8'h2D, 8'hF1);
    vb = 8'h7F;
    av = 8'hFF;
    pk(2);
    chk("shut", {7'b0, shut}, 8'h01);
    chk("prot", act.prot, 8'hF1);
    vb = 8'h80;
    pk(1);
    chk("equal", {7'b0, shut}, 8'h00);
    vb = 8'h10;
    host.wr(8'h2D, 8'h0F);
    pk(2);
    chk("avdd", {7'b0, shut}, 8'h00);
    chk("gens", act.prot, 8'h0F);
  endtask : t_uv
  task automatic t_plim;
    gp = 1;
    host.wr(8'h2B, 8'hD0);
    pk(2);
    chk("att", {5'b0, att}, 8'h05);
    host.wr(8'h2B, 8'hA0);
    pk(2);
    chk("hold", {5'b0, att}, 8'h05);
    gp = 0;
    host.wr(8'h2B, 8'hA4);
    pk(2);
    chk("recover", {5'b0, att}, 8'h00);
    lut = 3'h3;
    host.wr(8'h2B, 8'h88);
    pk(2);
    chk("lut", {5'b0, att}, 8'h03);
    host.wr(8'h2B, 8'h08);
    pk(2);
    chk("off", {5'b0, att}, 8'h00);
  endtask : t_plim
  // Mid-run reset must clear applied config too
  task automatic t_reset;
    host.wr(8'h2D, 8'hF1);
    pk(1);
    @(negedge ref_clk) rstn = 0;
    repeat (2) @(negedge ref_clk);
    rstn = 1;
    chk("rst prot", act.prot, 8'h00);
    chk("rst uvth", act.uvth, 8'hBF);
    chk("rst att", {5'b0, att}, 8'h00);
    host.rd(8'h2D, v);
    chk("rst read", v, 8'h00);
  endtask : t_reset
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      num_errors++;
      test_done();
    end
  end
  initial
  begin
    repeat (20) @(negedge ref_clk);
    rstn = 1;
    t_regs();
    t_apply();
    t_uv();
    t_plim();
    t_reset();
    test_done();
  end
endmodule : tb_top
`default_nettype wire

// ### verilog/adfcr_defines.svh
`ifndef ADFCR_DEFINES_SVH
`define ADFCR_DEFINES_SVH
`define ADFCR_OFS_ACT_CLK 8'h20
`define ADFCR_OFS_LIM_ROUTE 8'h23
`define ADFCR_OFS_GC_EN 8'h24
`define ADFCR_OFS_PLIM 8'h2B
`define ADFCR_OFS_MIXER 8'h2C
`define ADFCR_OFS_PROT 8'h2D
`define ADFCR_OFS_UVTH 8'h2E
`define ADFCR_RST_CFG 8'h00
`define ADFCR_RST_UVTH 8'hBF
`define ADFCR_WMASK_ACT_CLK 8'hFC
`define ADFCR_WMASK_LIM_ROUTE 8'hF0
`define ADFCR_WMASK_GC_EN 8'hFF
`define ADFCR_WMASK_PLIM 8'hFC
`define ADFCR_WMASK_MIXER 8'hF0
`define ADFCR_WMASK_PROT 8'hFF
`define ADFCR_WMASK_UVTH 8'hFF
`define ADFCR_RMASK_ACT_CLK 8'hF4
`endif

// ### verilog/adfcr_pkg.sv
package adfcr_pkg;
  typedef enum logic [1:0] {
    ADFCR_CLK_OSC = 2'b00,
    ADFCR_CLK_BIT = 2'b01,
    ADFCR_CLK_CTRL_PIN = 2'b10,
    ADFCR_CLK_CUSTOM = 2'b11
  } adfcr_clk_sel_t;
  typedef struct packed {
    logic [7:0] act_clk;
    logic [7:0] lim_route;
    logic [7:0] gc_en;
    logic [7:0] plim;
    logic [7:0] mixer;
    logic [7:0] prot;
    logic [7:0] uvth;
  } adfcr_regs_t;
  typedef struct packed {
    adfcr_regs_t shadow;
    adfcr_regs_t active;
    logic [7:0] rdata;
    logic [2:0] atten;
    logic shutdown;
  } adfcr_state_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } adfcr_bus_t;
endpackage : adfcr_pkg

// ### verilog/adfcr_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "adfcr_defines.svh"
module adfcr_regs
  import adfcr_pkg::*;
(
  input wire logic ref_clk, // 20 MHz clock
  input wire logic rstn, // Async reset, active low
  input wire adfcr_bus_t bus, // Control port access
  input wire logic sample_tick, // Sample boundary strobe
  input wire logic gpio_val, // Power limit GPIO level
  input wire logic [2:0] sar_lut_atten, // Attenuation from SAR table
  input wire logic sar_recovered, // SAR says supply recovered
  input wire logic [7:0] sar_vbat, // SAR battery data
  input wire logic [7:0] sar_avdd, // SAR analog supply data
  output logic [7:0] rdata, // Read data, valid cycle after rd
  output adfcr_regs_t cfg_active, // Configuration seen by datapath
  output logic [2:0] plim_atten, // Applied attenuation code
  output logic undervoltage_shutdown // Shutdown request
);
  adfcr_state_t st_r;
  adfcr_state_t st_nxt;
  logic [7:0] sel_sar;
  logic [2:0] target;
  logic [7:0] rd_mux;
  logic addr_mapped;
  always_comb
  begin
    st_nxt = st_r;
    rd_mux = 8'h00;
    addr_mapped = 1'b1;
    if (bus.wr)
    begin
      case (bus.addr)
        `ADFCR_OFS_ACT_CLK: st_nxt.shadow.act_clk = bus.wdata & `ADFCR_WMASK_ACT_CLK;
        `ADFCR_OFS_LIM_ROUTE: st_nxt.shadow.lim_route = bus.wdata & `ADFCR_WMASK_LIM_ROUTE;
        `ADFCR_OFS_GC_EN: st_nxt.shadow.gc_en = bus.wdata & `ADFCR_WMASK_GC_EN;
        `ADFCR_OFS_PLIM: st_nxt.shadow.plim = bus.wdata & `ADFCR_WMASK_PLIM;
        `ADFCR_OFS_MIXER: st_nxt.shadow.mixer = bus.wdata & `ADFCR_WMASK_MIXER;
        `ADFCR_OFS_PROT: st_nxt.shadow.prot = bus.wdata & `ADFCR_WMASK_PROT;
        `ADFCR_OFS_UVTH: st_nxt.shadow.uvth = bus.wdata & `ADFCR_WMASK_UVTH;
        default: st_nxt.shadow = st_r.shadow;
      endcase
    end
    case (bus.addr)
      // Bit 3 of activity register stores but reads zero
      `ADFCR_OFS_ACT_CLK: rd_mux = st_r.shadow.act_clk & `ADFCR_RMASK_ACT_CLK;
      `ADFCR_OFS_LIM_ROUTE: rd_mux = st_r.shadow.lim_route;
      `ADFCR_OFS_GC_EN: rd_mux = st_r.shadow.gc_en;
      `ADFCR_OFS_PLIM: rd_mux = st_r.shadow.plim;
      `ADFCR_OFS_MIXER: rd_mux = st_r.shadow.mixer;
      `ADFCR_OFS_PROT: rd_mux = st_r.shadow.prot;
      `ADFCR_OFS_UVTH: rd_mux = st_r.shadow.uvth;
      default:
      begin
        rd_mux = 8'h00;
        addr_mapped = 1'b0;
      end
    endcase
    if (bus.rd)
    begin
      st_nxt.rdata = rd_mux;
    end
    if (sample_tick)
    begin
      st_nxt.active = st_r.shadow;
    end
    sel_sar = st_r.active.prot[1] ? sar_avdd : sar_vbat;
    target = st_r.active.plim[3] ? sar_lut_atten : (gpio_val ? st_r.active.plim[6:4] : 3'h0);
    if (!st_r.active.plim[7])
    begin
      st_nxt.atten = 3'h0;
    end
    else if (sample_tick)
    begin
      if (target > st_r.atten)
      begin
        st_nxt.atten = target;
      end
      else if (st_r.active.plim[2] && (!gpio_val || sar_recovered))
      begin
        st_nxt.atten = target;
      end
    end
    st_nxt.shutdown = st_r.active.prot[0] && (sel_sar < st_r.active.uvth);
  end
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r <= {{6{`ADFCR_RST_CFG}}, `ADFCR_RST_UVTH, {6{`ADFCR_RST_CFG}}, `ADFCR_RST_UVTH,
               `ADFCR_RST_CFG, 3'h0, 1'b0};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end
  assign cfg_active = st_r.active;
  assign rdata = st_r.rdata;
  assign plim_atten = st_r.atten;
  assign undervoltage_shutdown = st_r.shutdown;
  atten_off_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !st_r.active.plim[7] |=> plim_atten == 3'h0) else $error("attenuation while off");
  no_recover_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (st_r.active.plim[7] && !st_r.active.plim[2] && $stable(st_r.active.plim))
    |=> plim_atten >= $past(plim_atten)) else $error("attenuation fell");
  boundary_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !sample_tick |=> $stable(cfg_active)) else $error("config changed off boundary");
  reserved_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    st_r.shadow.lim_route[3:0] == 4'h0 && st_r.shadow.plim[1:0] == 2'h0)
    else $error("reserved bit set");
  shut_off_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !cfg_active.prot[0] |=> !undervoltage_shutdown) else $error("shutdown while off");
  shut_on_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (cfg_active.prot[0] && !cfg_active.prot[1] && sar_vbat < cfg_active.uvth)
    |=> undervoltage_shutdown) else $error("missed shutdown");
  gpio_src_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (sample_tick && cfg_active.plim[7] && !cfg_active.plim[3] && gpio_val
    && cfg_active.plim[6:4] > plim_atten) |=> plim_atten == $past(cfg_active.plim[6:4]))
    else $error("gpio attenuation not applied");
  readback_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (bus.rd && bus.addr == `ADFCR_OFS_GC_EN) |=> rdata == $past(st_r.shadow.gc_en))
    else $error("readback wrong");
  wr_actclk_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    bus.wr && bus.addr == `ADFCR_OFS_ACT_CLK
    |=> st_r.shadow.act_clk == ($past(bus.wdata) & `ADFCR_WMASK_ACT_CLK))
    else $error("activity write lost");
  wr_limroute_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    bus.wr && bus.addr == `ADFCR_OFS_LIM_ROUTE
    |=> st_r.shadow.lim_route == ($past(bus.wdata) & `ADFCR_WMASK_LIM_ROUTE))
    else $error("limiter write lost");
  wr_gcen_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    bus.wr && bus.addr == `ADFCR_OFS_GC_EN
    |=> st_r.shadow.gc_en == ($past(bus.wdata) & `ADFCR_WMASK_GC_EN))
    else $error("channel enable write lost");
  wr_plim_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    bus.wr && bus.addr == `ADFCR_OFS_PLIM
    |=> st_r.shadow.plim == ($past(bus.wdata) & `ADFCR_WMASK_PLIM))
    else $error("power limiter write lost");
  wr_mixer_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    bus.wr && bus.addr == `ADFCR_OFS_MIXER
    |=> st_r.shadow.mixer == ($past(bus.wdata) & `ADFCR_WMASK_MIXER))
    else $error("mixer write lost");
  wr_prot_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    bus.wr && bus.addr == `ADFCR_OFS_PROT
    |=> st_r.shadow.prot == ($past(bus.wdata) & `ADFCR_WMASK_PROT))
    else $error("protection write lost");
  wr_uvth_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    bus.wr && bus.addr == `ADFCR_OFS_UVTH
    |=> st_r.shadow.uvth == ($past(bus.wdata) & `ADFCR_WMASK_UVTH))
    else $error("threshold write lost");
  wr_unmapped_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    bus.wr && !addr_mapped
    |=> $stable(st_r.shadow))
    else $error("unmapped write stored");
  rd_unmapped_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    bus.rd && !addr_mapped
    |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  rd_actclk_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    bus.rd && bus.addr == `ADFCR_OFS_ACT_CLK
    |=> rdata == ($past(st_r.shadow.act_clk) & `ADFCR_RMASK_ACT_CLK))
    else $error("activity readback wrong");
  rd_limroute_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    bus.rd && bus.addr == `ADFCR_OFS_LIM_ROUTE
    |=> rdata == $past(st_r.shadow.lim_route))
    else $error("limiter readback wrong");
  rd_plim_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    bus.rd && bus.addr == `ADFCR_OFS_PLIM
    |=> rdata == $past(st_r.shadow.plim))
    else $error("power limiter readback wrong");
  rd_mixer_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    bus.rd && bus.addr == `ADFCR_OFS_MIXER
    |=> rdata == $past(st_r.shadow.mixer))
    else $error("mixer readback wrong");
  rd_prot_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    bus.rd && bus.addr == `ADFCR_OFS_PROT
    |=> rdata == $past(st_r.shadow.prot))
    else $error("protection readback wrong");
  rd_uvth_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    bus.rd && bus.addr == `ADFCR_OFS_UVTH
    |=> rdata == $past(st_r.shadow.uvth))
    else $error("threshold readback wrong");
  clk_sel_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_tick
    |=> cfg_active.act_clk[7:6] == $past(st_r.shadow.act_clk[7:6]))
    else $error("clock select not applied");
  clk_rate_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_tick
    |=> cfg_active.act_clk[5:4] == $past(st_r.shadow.act_clk[5:4]))
    else $error("clock rate not applied");
  phase_one_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_tick
    |=> cfg_active.act_clk[2] == $past(st_r.shadow.act_clk[2]))
    else $error("phase one enable not applied");
  lim_input_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_tick
    |=> cfg_active.lim_route[7:6] == $past(st_r.shadow.lim_route[7:6]))
    else $error("limiter input not applied");
  lim_output_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_tick
    |=> cfg_active.lim_route[5:4] == $past(st_r.shadow.lim_route[5:4]))
    else $error("limiter output not applied");
  gain_en_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_tick
    |=> cfg_active.gc_en[7:4] == $past(st_r.shadow.gc_en[7:4]))
    else $error("gain enables not applied");
  comp_en_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_tick
    |=> cfg_active.gc_en[3:0] == $past(st_r.shadow.gc_en[3:0]))
    else $error("compression enables not applied");
  plim_en_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_tick
    |=> cfg_active.plim[7] == $past(st_r.shadow.plim[7]))
    else $error("limiter enable not applied");
  atten_field_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_tick
    |=> cfg_active.plim[6:4] == $past(st_r.shadow.plim[6:4]))
    else $error("attenuation field not applied");
  atten_src_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_tick
    |=> cfg_active.plim[3] == $past(st_r.shadow.plim[3]))
    else $error("attenuation source not applied");
  recover_bit_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_tick
    |=> cfg_active.plim[2] == $past(st_r.shadow.plim[2]))
    else $error("recovery bit not applied");
  mixer_en_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_tick
    |=> cfg_active.mixer[7:4] == $past(st_r.shadow.mixer[7:4]))
    else $error("mixer enables not applied");
  distortion_en_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_tick
    |=> cfg_active.prot[7] == $past(st_r.shadow.prot[7]))
    else $error("distortion enable not applied");
  battery_en_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_tick
    |=> cfg_active.prot[6] == $past(st_r.shadow.prot[6]))
    else $error("battery protection not applied");
  thermal_en_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_tick
    |=> cfg_active.prot[5] == $past(st_r.shadow.prot[5]))
    else $error("thermal rollback not applied");
  global_comp_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_tick
    |=> cfg_active.prot[4] == $past(st_r.shadow.prot[4]))
    else $error("global compression not applied");
  generator_en_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_tick
    |=> cfg_active.prot[3:2] == $past(st_r.shadow.prot[3:2]))
    else $error("generator enables not applied");
  sar_choice_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_tick
    |=> cfg_active.prot[1] == $past(st_r.shadow.prot[1]))
    else $error("SAR choice not applied");
  shut_en_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_tick
    |=> cfg_active.prot[0] == $past(st_r.shadow.prot[0]))
    else $error("shutdown enable not applied");
  uvth_apply_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_tick
    |=> cfg_active.uvth == $past(st_r.shadow.uvth))
    else $error("threshold not applied");
  recover_drop_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_tick && cfg_active.plim[7] && cfg_active.plim[2] && !cfg_active.plim[3] && !gpio_val
    |=> plim_atten == 3'h0)
    else $error("attenuation did not recover");
  lut_src_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    sample_tick && cfg_active.plim[7] && cfg_active.plim[3] && sar_lut_atten > plim_atten
    |=> plim_atten == $past(sar_lut_atten))
    else $error("table attenuation not applied");
  avdd_shut_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    cfg_active.prot[0] && cfg_active.prot[1] && sar_avdd < cfg_active.uvth
    |=> undervoltage_shutdown)
    else $error("missed supply shutdown");
  shut_clear_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    cfg_active.prot[0] && !cfg_active.prot[1] && sar_vbat >= cfg_active.uvth
    |=> !undervoltage_shutdown)
    else $error("shutdown above threshold");
  atten_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !sample_tick && cfg_active.plim[7]
    |=> $stable(plim_atten))
    else $error("attenuation changed off boundary");
endmodule : adfcr_regs
`default_nettype wire
